/* rtl/mss_starter.sv */
/*
  Motor starter control: quick stop, interlocked manual mode, lower current trip, diagnostic readout,
  and an APB register slave. Assumes all pin inputs synchronous to i_sys_clk except the limit inputs,
  which are synchronised and filtered here; APB master per the usual two-phase protocol.
*/
// Notes on behaviour
// - A limit rising edge opens its assigned contactor without bus involvement.
// - Restart after quick stop needs direction bit fall then rise; limit level ignored.
// - Break contact setting inverts limit input polarity.
// - Direction LED steady while bit set, flashing when quick stopped.
// - First limit edge or level locks manual forward; reverse stays selectable.
// - Forward unlocks on first limit fall during reverse, or auto and back.
// - Second limit locks manual reverse the same way.
// - Direct online with pole six set, pole eight clear: edge-only interlock.
// - Manual LED lit on selection, flashing when interlock holds contactor off.
// - Interlock only acts while fieldbus supply is present.
// - Phase below 35 percent of setpoint raises group fault, opens contactor.
// - Currents above 40 percent of setpoint never trip.
// - Reset command clears lower current trip in both modes.
// - Writing 111 with diagnostics enabled returns the diagnostic code.
// - With no diagnostic present, request 111 is answered with 111.
// - Any other parameter value is echoed unchanged.
// - Highest priority latched message reported until cause gone and reset.
// - Manual and load messages clear by themselves.
// - Contactor faulty: code 001, group fault and peripheral flag set.
// - Overload at 110 percent: code 010, group fault, no peripheral flag.
// - Thermistor 011 fault; manual 100 no fault; no-diagnosis 111 fault.
// - Load 90 percent gives 101, 70 percent gives 110, no group fault.
// - Auto mode: both bits low 18.5 ms then high 18.5 ms is a reset.
`timescale 1ns/1ps
module mss_starter #(
  parameter int unsigned TICK_CYCLES = mss_pkg::TICK_CYC,
  parameter int unsigned HOLD = mss_pkg::HOLD_TICKS,
  parameter int unsigned FLASH = mss_pkg::FLASH_TICKS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_first_limit_input,
  input wire logic i_second_limit_input,
  input wire logic i_key_auto,
  input wire logic i_key_manual,
  input wire logic i_sel_forward,
  input wire logic i_sel_reverse,
  input wire logic i_bus_supply_ok,
  input wire mss_pkg::mss_phase_t i_phase_current,
  input wire logic [mss_pkg::PCT_W-1:0] i_thermal_pct,
  input wire logic i_thermistor_trip,
  input wire logic i_current_without_actuation,
  input wire logic i_no_diag_cause,
  output logic o_forward_run,
  output logic o_reverse_run,
  output logic o_led_forward,
  output logic o_led_reverse,
  output logic o_group_fault_bit,
  output logic o_peripheral_fault_flag
);
  import mss_pkg::*;

  mss_cfg_t cfg_reg;
  logic forward_command_bit_reg;
  logic reverse_command_bit_reg;
  logic [CUR_W-1:0] setp_reg;
  logic [2:0] param_ans_reg;
  logic [15:0] tick_cnt_reg;
  logic tick;
  logic [CNT_W-1:0] flash_cnt_reg;
  logic flash_reg;

  // Timebase: one 0.1 ms enable pulse; the flash toggle runs off it.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      tick_cnt_reg <= '0;
    else if (tick)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end
  assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      flash_cnt_reg <= '0;
      flash_reg <= 1'b0;
    end
    else if (tick)
    begin
      if (flash_cnt_reg == CNT_W'(FLASH - 1))
      begin
        flash_cnt_reg <= '0;
        flash_reg <= ~flash_reg;
      end
      else
        flash_cnt_reg <= flash_cnt_reg + 1'b1;
    end
  end

  logic lim1, lim1_rise, lim1_fall, lim2, lim2_rise, lim2_fall;
  mss_filter #(.HOLD(HOLD), .W(CNT_W)) u_lim1 (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_raw(i_first_limit_input),
    .i_invert(cfg_reg.break_contact),
    .o_level(lim1),
    .o_rise(lim1_rise),
    .o_fall(lim1_fall)
  );
  mss_filter #(.HOLD(HOLD), .W(CNT_W)) u_lim2 (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_raw(i_second_limit_input),
    .i_invert(cfg_reg.break_contact),
    .o_level(lim2),
    .o_rise(lim2_rise),
    .o_fall(lim2_fall)
  );

  // Mode tracking and key-switch reset on entering OFF.
  logic auto_d_reg, manual_d_reg, key_reset, back_to_manual;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      auto_d_reg <= 1'b0;
      manual_d_reg <= 1'b0;
    end
    else
    begin
      auto_d_reg <= i_key_auto;
      manual_d_reg <= i_key_manual;
    end
  end
  assign key_reset = (auto_d_reg | manual_d_reg) & ~i_key_auto & ~i_key_manual;
  assign back_to_manual = i_key_manual & ~manual_d_reg & auto_d_reg;

  // Bus reset sequence: both bits low for the hold time, then both high for the hold time.
  mss_rs_state_t rs_state_reg;
  logic [CNT_W-1:0] rs_cnt_reg;
  logic bus_reset;
  logic both_low, both_high, rs_done;
  assign both_low = ~forward_command_bit_reg & ~reverse_command_bit_reg;
  assign both_high = forward_command_bit_reg & reverse_command_bit_reg;
  assign rs_done = tick && (rs_cnt_reg == CNT_W'(HOLD - 1));
  assign bus_reset = (rs_state_reg == RS_HIGH) && both_high && rs_done && i_key_auto;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rs_state_reg <= RS_IDLE;
      rs_cnt_reg <= '0;
    end
    else if (!i_key_auto)
    begin
      rs_state_reg <= RS_IDLE;
      rs_cnt_reg <= '0;
    end
    else
    begin
      if (tick)
        rs_cnt_reg <= rs_cnt_reg + 1'b1;
      case (rs_state_reg)
        RS_IDLE:
        begin
          rs_cnt_reg <= '0;
          if (both_low)
            rs_state_reg <= RS_LOW;
        end
        RS_LOW:
        begin
          if (!both_low)
            rs_state_reg <= RS_IDLE;
          else if (rs_done)
            rs_state_reg <= RS_ARMED;
        end
        RS_ARMED:
        begin
          rs_cnt_reg <= '0;
          if (both_high)
            rs_state_reg <= RS_HIGH;
          else if (!both_low)
            rs_state_reg <= RS_IDLE;
        end
        RS_HIGH:
        begin
          if (!both_high || rs_done)
            rs_state_reg <= RS_IDLE;
        end
        default:
          rs_state_reg <= RS_IDLE;
      endcase
    end
  end

  logic reset_cmd;
  assign reset_cmd = bus_reset | key_reset;

  // Quick stop source routing by pole six and pole eight.
  logic edge_only, route_a, route_b, qs_fwd_hit, qs_rev_hit;
  logic qs_fwd_reg, qs_rev_reg;
  assign route_a = cfg_reg.pole6 & ~cfg_reg.pole8;
  assign route_b = ~cfg_reg.pole6 & cfg_reg.pole8;
  assign qs_fwd_hit = cfg_reg.qstop_sel & i_key_auto & forward_command_bit_reg &
                      ((route_a & (lim1_rise | (cfg_reg.direct_online_variant & lim2_rise))) |
                       (route_b & lim1_rise));
  assign qs_rev_hit = cfg_reg.qstop_sel & i_key_auto & reverse_command_bit_reg &
                      ((route_a & ~cfg_reg.direct_online_variant & lim1_rise) | (route_b & lim2_rise));

  // Only a falling command bit releases the stop; limit level is not looked at.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      qs_fwd_reg <= 1'b0;
      qs_rev_reg <= 1'b0;
    end
    else
    begin
      if (qs_fwd_hit)
        qs_fwd_reg <= 1'b1;
      else if (!forward_command_bit_reg)
        qs_fwd_reg <= 1'b0;
      if (qs_rev_hit)
        qs_rev_reg <= 1'b1;
      else if (!reverse_command_bit_reg)
        qs_rev_reg <= 1'b0;
    end
  end

  // Interlocked manual mode.
  logic ilk_active, lock_fwd_reg, lock_rev_reg;
  assign ilk_active = ~cfg_reg.qstop_sel & i_bus_supply_ok;
  assign edge_only = cfg_reg.direct_online_variant & route_a;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lock_fwd_reg <= 1'b0;
      lock_rev_reg <= 1'b0;
    end
    else
    begin
      if (ilk_active && (lim1_rise || (!edge_only && lim1)))
        lock_fwd_reg <= 1'b1;
      else if ((lim1_fall && o_reverse_run) || back_to_manual)
        lock_fwd_reg <= 1'b0;
      if (ilk_active && (lim2_rise || (!edge_only && lim2)))
        lock_rev_reg <= 1'b1;
      else if ((lim2_fall && o_forward_run) || back_to_manual)
        lock_rev_reg <= 1'b0;
    end
  end

  // Lower current supervision, compared as products so no divider is needed.
  logic lc_low;
  always_comb
  begin
    logic [PRD_W-1:0] lim;
    lim = PRD_W'(setp_reg) * LC_TRIP_PCT;
    lc_low = cfg_reg.lc_en && (o_forward_run || o_reverse_run) &&
             ((PRD_W'(i_phase_current.l1) * PCT_FULL < lim) ||
              (PRD_W'(i_phase_current.l2) * PCT_FULL < lim) ||
              (PRD_W'(i_phase_current.l3) * PCT_FULL < lim));
  end

  // Latched faults: a cause that is still present when the reset arrives keeps its bit.
  logic [3:0] cause, fault_reg;
  assign cause[F_CONTACTOR] = i_current_without_actuation;
  assign cause[F_OVERLOAD] = i_thermal_pct >= OVL_PCT;
  assign cause[F_THERMISTOR] = i_thermistor_trip;
  assign cause[F_NODIAG] = lc_low | i_no_diag_cause;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      fault_reg <= '0;
    else
      for (int i = 0; i < 4; i++)
        if (cause[i])
          fault_reg[i] <= 1'b1;
        else if (reset_cmd)
          fault_reg[i] <= 1'b0;
  end

  logic trip;
  assign trip = |fault_reg;

  // Contactors are registered; the hit terms cut the drive in the same cycle the stop latches.
  logic auto_fwd, auto_rev, man_fwd, man_rev;
  assign auto_fwd = i_key_auto & forward_command_bit_reg & ~reverse_command_bit_reg & ~qs_fwd_reg & ~qs_fwd_hit;
  assign auto_rev = i_key_auto & reverse_command_bit_reg & ~forward_command_bit_reg & ~qs_rev_reg & ~qs_rev_hit;
  assign man_fwd = i_key_manual & i_sel_forward & ~i_sel_reverse & ~(ilk_active & lock_fwd_reg);
  assign man_rev = i_key_manual & i_sel_reverse & ~i_sel_forward & ~(ilk_active & lock_rev_reg);

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_forward_run <= 1'b0;
      o_reverse_run <= 1'b0;
    end
    else
    begin
      o_forward_run <= ~trip & ~lc_low & (auto_fwd | man_fwd);
      o_reverse_run <= ~trip & ~lc_low & ~cfg_reg.direct_online_variant & (auto_rev | man_rev);
    end
  end

  // Direction LEDs.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_led_forward <= 1'b0;
      o_led_reverse <= 1'b0;
    end
    else if (i_key_manual)
    begin
      o_led_forward <= i_sel_forward & (~(ilk_active & lock_fwd_reg) | flash_reg);
      o_led_reverse <= i_sel_reverse & (~(ilk_active & lock_rev_reg) | flash_reg);
    end
    else
    begin
      o_led_forward <= forward_command_bit_reg & (~qs_fwd_reg | flash_reg);
      o_led_reverse <= reverse_command_bit_reg & (~qs_rev_reg | flash_reg);
    end
  end

  // Diagnostic code by priority.
  logic [2:0] diag_code;
  always_comb
  begin
    if (fault_reg[F_CONTACTOR])
      diag_code = DIAG_CONTACTOR;
    else if (fault_reg[F_OVERLOAD])
      diag_code = DIAG_OVERLOAD;
    else if (fault_reg[F_THERMISTOR])
      diag_code = DIAG_THERMISTOR;
    else if (fault_reg[F_NODIAG])
      diag_code = DIAG_NONE;
    else if (i_key_manual)
      diag_code = DIAG_MANUAL;
    else if (i_thermal_pct >= LOAD90_PCT)
      diag_code = DIAG_LOAD90;
    else if (i_thermal_pct >= LOAD70_PCT)
      diag_code = DIAG_LOAD70;
    else
      diag_code = DIAG_NONE;
  end

  assign o_group_fault_bit = trip;
  assign o_peripheral_fault_flag = fault_reg[F_CONTACTOR];

  // APB slave: zero wait states, read data captured in the setup cycle.
  logic wr, mapped;
  assign wr = i_psel & i_penable & i_pwrite;
  assign mapped = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_CMD) || (i_paddr == ADDR_SETP) ||
                  (i_paddr == ADDR_PARAM) || (i_paddr == ADDR_STATUS);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cfg_reg <= CTRL_RST;
      forward_command_bit_reg <= 1'b0;
      reverse_command_bit_reg <= 1'b0;
      setp_reg <= SETP_RST;
      param_ans_reg <= '0;
    end
    else if (wr)
    begin
      case (i_paddr)
        ADDR_CTRL:
          cfg_reg <= i_pwdata[6:0];
        ADDR_CMD:
        begin
          forward_command_bit_reg <= i_pwdata[0];
          reverse_command_bit_reg <= i_pwdata[1];
        end
        ADDR_SETP:
          setp_reg <= i_pwdata[CUR_W-1:0];
        ADDR_PARAM:
          if (cfg_reg.diag_en && i_pwdata[2:0] == PARAM_REQ)
            param_ans_reg <= diag_code;
          else
            param_ans_reg <= i_pwdata[2:0];
        default:
          cfg_reg <= cfg_reg;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_prdata <= '0;
    else if (i_psel && !i_penable && !i_pwrite)
      case (i_paddr)
        ADDR_CTRL: o_prdata <= {25'h0, cfg_reg};
        ADDR_CMD: o_prdata <= {30'h0, reverse_command_bit_reg, forward_command_bit_reg};
        ADDR_SETP: o_prdata <= {20'h00000, setp_reg};
        ADDR_PARAM: o_prdata <= {29'h0, param_ans_reg};
        ADDR_STATUS: o_prdata <= {16'h0000, rs_state_reg, 1'b0, diag_code, o_peripheral_fault_flag, trip,
                                  lock_rev_reg, lock_fwd_reg, qs_rev_reg, qs_fwd_reg, o_reverse_run, o_forward_run};
        default: o_prdata <= '0;
      endcase
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_qs_cut;
    qs_fwd_hit |=> !o_forward_run;
  endproperty
  a_qs_cut: assert property (p_qs_cut) else $error("quick stop did not open forward contactor");
  property p_qs_hold;
    qs_fwd_reg && forward_command_bit_reg |=> qs_fwd_reg;
  endproperty
  a_qs_hold: assert property (p_qs_hold) else $error("quick stop released while bit set");
  property p_qs_off;
    qs_fwd_reg |-> !o_forward_run || $past(!qs_fwd_reg);
  endproperty
  a_qs_off: assert property (p_qs_off) else $error("forward runs while quick stopped");
  property p_lock;
    i_key_manual && ilk_active && lock_fwd_reg |=> !o_forward_run;
  endproperty
  a_lock: assert property (p_lock) else $error("manual forward ran while locked");
  property p_nosupply;
    $rose(lim1) && !i_bus_supply_ok && !lock_fwd_reg |=> !lock_fwd_reg;
  endproperty
  a_nosupply: assert property (p_nosupply) else $error("interlock set without supply");
  property p_lc;
    lc_low |=> o_group_fault_bit && !o_forward_run && !o_reverse_run;
  endproperty
  a_lc: assert property (p_lc) else $error("lower current did not trip");
  property p_reset;
    reset_cmd && cause == 4'h0 |=> !o_group_fault_bit;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not clear faults");
  property p_echo;
    wr && i_paddr == ADDR_PARAM && i_pwdata[2:0] != PARAM_REQ |=> param_ans_reg == $past(i_pwdata[2:0]);
  endproperty
  a_echo: assert property (p_echo) else $error("parameter echo wrong");
  property p_prio;
    fault_reg[F_CONTACTOR] |-> diag_code == DIAG_CONTACTOR && o_peripheral_fault_flag;
  endproperty
  a_prio: assert property (p_prio) else $error("contactor fault not top priority");
  property p_rs;
    bus_reset |-> $past(rs_state_reg == RS_HIGH) && both_high;
  endproperty
  a_rs: assert property (p_rs) else $error("bus reset outside sequence");

  c_qs: cover property (qs_fwd_hit ##[1:20] !forward_command_bit_reg);
  c_lock: cover property (lock_fwd_reg && i_key_manual && i_sel_forward);
  c_bus_reset: cover property (bus_reset);
  c_diag: cover property (wr && i_paddr == ADDR_PARAM && cfg_reg.diag_en && i_pwdata[2:0] == PARAM_REQ);
endmodule : mss_starter

/* rtl/mss_filter.sv */
/*
  Shared constants and types of the motor starter stop, interlock and diagnostic block, and the
  limit input conditioner. Assumes a 10 MHz system clock and a 0.1 ms tick enable made by the top.
*/
`timescale 1ns/1ps
package mss_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_NS = 100_000;
  localparam int unsigned TICK_CYC = (CLK_HZ / 1_000_000) * TICK_NS / 1000;
  localparam int unsigned HOLD_US = 18_500;
  localparam int unsigned HOLD_TICKS = (HOLD_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_TICKS = FLASH_MS * 1_000_000 / TICK_NS;
  localparam int unsigned CNT_W = 14;
  localparam int unsigned CUR_W = 12;
  localparam int unsigned PCT_W = 8;
  localparam int unsigned PRD_W = 20;
  localparam logic [PRD_W-1:0] PCT_FULL = 20'h00064;
  localparam logic [PRD_W-1:0] LC_TRIP_PCT = 20'h00023;
  localparam logic [PCT_W-1:0] OVL_PCT = 8'h6e;
  localparam logic [PCT_W-1:0] LOAD90_PCT = 8'h5a;
  localparam logic [PCT_W-1:0] LOAD70_PCT = 8'h46;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_SETP = 8'h08;
  localparam logic [7:0] ADDR_PARAM = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [CUR_W-1:0] SETP_RST = 12'h000;
  localparam logic [2:0] DIAG_CONTACTOR = 3'h1;
  localparam logic [2:0] DIAG_OVERLOAD = 3'h2;
  localparam logic [2:0] DIAG_THERMISTOR = 3'h3;
  localparam logic [2:0] DIAG_MANUAL = 3'h4;
  localparam logic [2:0] DIAG_LOAD90 = 3'h5;
  localparam logic [2:0] DIAG_LOAD70 = 3'h6;
  localparam logic [2:0] DIAG_NONE = 3'h7;
  localparam logic [2:0] PARAM_REQ = 3'h7;
  localparam int unsigned F_CONTACTOR = 0;
  localparam int unsigned F_OVERLOAD = 1;
  localparam int unsigned F_THERMISTOR = 2;
  localparam int unsigned F_NODIAG = 3;

  typedef struct packed {
    logic diag_en;
    logic lc_en;
    logic break_contact;
    logic direct_online_variant;
    logic pole8;
    logic pole6;
    logic qstop_sel;
  } mss_cfg_t;

  typedef struct packed {
    logic [CUR_W-1:0] l3;
    logic [CUR_W-1:0] l2;
    logic [CUR_W-1:0] l1;
  } mss_phase_t;

  typedef enum logic [3:0] {
    RS_IDLE = 4'b0001,
    RS_LOW = 4'b0010,
    RS_ARMED = 4'b0100,
    RS_HIGH = 4'b1000
  } mss_rs_state_t;
endpackage : mss_pkg

module mss_filter #(
  parameter int unsigned HOLD = mss_pkg::HOLD_TICKS,
  parameter int unsigned W = mss_pkg::CNT_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_raw,
  input wire logic i_invert,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  import mss_pkg::*;
  logic sync1_reg;
  logic sync2_reg;
  logic [W-1:0] cnt_reg;
  logic act;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= i_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Break contacts read active low, so polarity is flipped after the synchroniser.
  assign act = sync2_reg ^ i_invert;

  // A new level is accepted only after it stood for the whole hold time; shorter pulses are dropped.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_reg <= '0;
      o_level <= 1'b0;
    end
    else if (act == o_level)
      cnt_reg <= '0;
    else if (i_tick)
    begin
      if (cnt_reg >= W'(HOLD - 1))
      begin
        o_level <= act;
        cnt_reg <= '0;
      end
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

  logic level_d_reg;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      level_d_reg <= 1'b0;
    else
      level_d_reg <= o_level;
  end
  assign o_rise = o_level & ~level_d_reg;
  assign o_fall = ~o_level & level_d_reg;
endmodule : mss_filter

/* dv/mss_sensor.sv */
/*
  Limit sensor model: raises a limit input for a chosen number of clocks on request.
  Assumes the bench pulses the request for one clock at a rising edge.
*/
`timescale 1ns/1ps
module mss_sensor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_go,
  input wire logic [7:0] i_len,
  output logic [1:0] o_lim
);
  logic [7:0] cnt [2];
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    for (int k = 0; k < 2; k++)
    begin
      if (i_rst)
        cnt[k] <= 8'h00;
      else if (i_go[k])
        cnt[k] <= i_len;
      else if (cnt[k] != 8'h00)
        cnt[k] <= cnt[k] - 8'h01;
    end
  end
  // The bench asks for a length above the hold time unless it means to be rejected.
  assign o_lim = {cnt[1] != 8'h00, cnt[0] != 8'h00};
endmodule : mss_sensor

/* dv/motor_starter_stop_interlock_diag_test.sv */
/*
  Bench for the starter: diagnostic readout, quick stop, lower current trip and interlocked manual mode.
  Assumes a zero wait APB slave and a tick every two clocks.
*/
`timescale 1ns/1ps
module motor_starter_stop_interlock_diag_test;
  import mss_pkg::*;
  logic i_sys_clk = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, pready, se, lf, fr, gf, pf;
  logic ka = 1, km = 0, sf = 0, sr = 0, sup = 1, tt = 0, cwa = 0, nd = 0, qe, rr, lr;
  mss_phase_t ph = '0;
  logic [1:0] go = 2'h0, lim;
  logic [7:0] paddr = 8'h00, len = 8'h00, th = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int fails = 0, check_count = 0, cyc = 0;
  always #50 i_sys_clk = ~i_sys_clk;
  mss_sensor i_sen (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_go(go), .i_len(len), .o_lim(lim));
  mss_starter #(.TICK_CYCLES(2), .HOLD(4), .FLASH(4)) i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(se), .i_first_limit_input(lim[0]), .i_second_limit_input(lim[1]),
    .i_key_auto(ka), .i_key_manual(km), .i_sel_forward(sf), .i_sel_reverse(sr), .i_bus_supply_ok(sup),
    .i_phase_current(ph), .i_thermal_pct(th), .i_thermistor_trip(tt), .i_current_without_actuation(cwa),
    .i_no_diag_cause(nd), .o_forward_run(fr), .o_reverse_run(rr), .o_led_forward(lf), .o_led_reverse(lr),
    .o_group_fault_bit(gf), .o_peripheral_fault_flag(pf));
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    pen <= 1'b1;
    do @(posedge i_sys_clk); while (pready !== 1'b1);
    q = prdata;
    qe = se;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic dg(input logic [2:0] c, input logic g);
    repeat (3) @(posedge i_sys_clk);
    apb(1'b1, ADDR_PARAM, 32'h7);
    apb(1'b0, ADDR_PARAM, 32'h0);
    chk(q[2:0], c);
    chk(gf, g);
  endtask : dg
  // A flashing LED shows both levels within seventeen clocks; a steady one does not.
  task automatic flashes;
    logic [1:0] seen;
    seen = 2'h0;
    repeat (17)
    begin
      @(posedge i_sys_clk);
      seen = seen | {lf, ~lf};
    end
    chk(seen, 2'h3);
  endtask : flashes
  // Both bits low, then both high, each past the hold time of four ticks.
  task automatic bus_reset;
    apb(1'b1, ADDR_CMD, 32'h0);
    repeat (12) @(posedge i_sys_clk);
    apb(1'b1, ADDR_CMD, 32'h3);
    repeat (12) @(posedge i_sys_clk);
    apb(1'b1, ADDR_CMD, 32'h0);
  endtask : bus_reset
  task automatic t_diag;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    chk(qe, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h40);
    dg(DIAG_NONE, 1'b0);
    apb(1'b1, ADDR_PARAM, 32'h5);
    apb(1'b0, ADDR_PARAM, 32'h0);
    chk(q, 32'h5);
    th <= 8'h46;
    dg(DIAG_LOAD70, 1'b0);
    th <= 8'h5a;
    dg(DIAG_LOAD90, 1'b0);
    th <= 8'h00;
    dg(DIAG_NONE, 1'b0);
    th <= 8'h6e;
    tt <= 1'b1;
    dg(DIAG_OVERLOAD, 1'b1);
    cwa <= 1'b1;
    dg(DIAG_CONTACTOR, 1'b1);
    chk(pf, 1'b1);
    cwa <= 1'b0;
    th <= 8'h00;
    dg(DIAG_CONTACTOR, 1'b1);
    bus_reset();
    dg(DIAG_THERMISTOR, 1'b1);
    tt <= 1'b0;
    nd <= 1'b1;
    bus_reset();
    dg(DIAG_NONE, 1'b1);
    nd <= 1'b0;
    bus_reset();
    dg(DIAG_NONE, 1'b0);
  endtask : t_diag
  task automatic t_qs;
    int n;
    apb(1'b1, ADDR_CTRL, 32'h45);
    apb(1'b1, ADDR_CMD, 32'h1);
    repeat (3) @(posedge i_sys_clk);
    chk(fr, 1'b1);
    len <= 8'h03;
    go <= 2'h1;
    @(posedge i_sys_clk);
    go <= 2'h0;
    repeat (30) @(posedge i_sys_clk);
    chk(fr, 1'b1);
    len <= 8'h50;
    go <= 2'h3;
    @(posedge i_sys_clk);
    go <= 2'h0;
    n = 0;
    while (fr !== 1'b0 && n < 60)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    chk(fr, 1'b0);
    repeat (2) @(posedge i_sys_clk);
    flashes();
    apb(1'b1, ADDR_CMD, 32'h0);
    apb(1'b1, ADDR_CMD, 32'h1);
    repeat (3) @(posedge i_sys_clk);
    chk({fr, lf}, 2'h3);
  endtask : t_qs
  // Setpoint 100: phases at 41 keep running, phases at 0 trip until a bus reset.
  task automatic t_lc;
    apb(1'b1, ADDR_CMD, 32'h0);
    apb(1'b1, ADDR_SETP, 32'h64);
    apb(1'b1, ADDR_CTRL, 32'h60);
    ph <= '{default: 12'h029};
    apb(1'b1, ADDR_CMD, 32'h1);
    repeat (4) @(posedge i_sys_clk);
    chk(fr, 1'b1);
    ph <= '{default: 12'h000};
    dg(DIAG_NONE, 1'b1);
    chk(fr, 1'b0);
    bus_reset();
    dg(DIAG_NONE, 1'b0);
  endtask : t_lc
  // The limit pulse is long enough that reverse is running when the filtered level falls.
  task automatic t_man;
    apb(1'b1, ADDR_CTRL, 32'h40);
    ka <= 1'b0;
    km <= 1'b1;
    dg(DIAG_MANUAL, 1'b0);
    sf <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    chk({fr, lf}, 2'h3);
    len <= 8'h40;
    go <= 2'h1;
    @(posedge i_sys_clk);
    go <= 2'h0;
    repeat (16) @(posedge i_sys_clk);
    chk(fr, 1'b0);
    flashes();
    sf <= 1'b0;
    sr <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    chk({rr, lr}, 2'h3);
    repeat (50) @(posedge i_sys_clk);
    sr <= 1'b0;
    sf <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    chk(fr, 1'b1);
    sup <= 1'b0;
    go <= 2'h1;
    @(posedge i_sys_clk);
    go <= 2'h0;
    repeat (16) @(posedge i_sys_clk);
    chk(fr, 1'b1);
    ka <= 1'b1;
    km <= 1'b0;
    sf <= 1'b0;
    sup <= 1'b1;
    dg(DIAG_NONE, 1'b0);
  endtask : t_man
  initial
  begin
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_diag();
    t_qs();
    t_lc();
    t_man();
    conclude();
  end
endmodule : motor_starter_stop_interlock_diag_test
